// *** rms_pkg.sv ***
/*
 * Shared constants and types for the reset and mode select block:
 * reset pin drive length, debug link bit timing, reset cause layout
 * and the reset sequencer states.
 * Assumes a single bus clock of 25 MHz; all counts are in bus cycles.
 */
package rms_pkg;

    // Reset pin is held low this many bus cycles on every reset
    localparam int         RST_DRIVE_CYCLES = 66;
    localparam logic [6:0] RST_DRIVE_LAST   = 7'(RST_DRIVE_CYCLES - 1);

    // Debug link bit timing, in debug clock (bus clock) cycles
    localparam int         BIT_CYCLES       = 16;
    localparam logic [3:0] BIT_LAST         = 4'(BIT_CYCLES - 1);
    localparam logic [3:0] RX_SAMPLE_CNT    = 4'hA;
    localparam logic [3:0] ZERO_LOW_LAST    = 4'hC;

    // Reset cause register layout
    localparam int         CAUSE_W          = 8;
    localparam int         CAUSE_POR        = 7;
    localparam int         CAUSE_PIN        = 6;
    localparam int         CAUSE_COP        = 5;
    localparam int         CAUSE_ILOP       = 4;
    localparam int         CAUSE_ILAD       = 3;
    localparam int         CAUSE_LVD        = 1;
    localparam int         CAUSE_FORCED     = 0;
    localparam logic [7:0] CAUSE_RESET      = 8'h80;

    // Sequencer states, Gray coded along drive, wait, sample, run
    typedef enum logic [1:0] {
        ST_DRIVE  = 2'h0,
        ST_WAIT   = 2'h1,
        ST_SAMPLE = 2'h3,
        ST_RUN    = 2'h2
    } rms_state_t;

endpackage : rms_pkg

// *** rms_bit_timer.sv ***
/*
 * Bit timer of the single-wire debug link: detects the host's falling
 * edge, times a 16-cycle bit, samples received data, stretches a zero
 * when transmitting and ends it with an active-high speedup pulse.
 * Assumes pin_i is synchronous to clk_i and the host starts each bit.
 */
module rms_bit_timer (
    input  wire logic clk_i,      // Debug clock, equal to bus clock
    input  wire logic arst_n_i,   // Asynchronous reset, active low
    input  wire logic enable_i,   // Link may start a new bit
    input  wire logic pin_i,      // Debug pin level
    input  wire logic tx_valid_i, // A bit is offered for sending
    input  wire logic tx_bit_i,   // Bit value to send
    output logic      tx_taken_o, // Offered bit taken this cycle
    output logic      rx_valid_o, // Received bit strobe
    output logic      rx_bit_o,   // Received bit value
    output logic      busy_o,     // Bit time in progress
    output logic      pin_o,      // Pin drive level
    output logic      pin_oe_o    // Pin drive enable
);

    logic       pin_prev;
    logic       active;
    logic [3:0] cnt;
    logic       drive_low;
    logic       speedup;
    logic       start;

    assign start      = enable_i && !active && pin_prev && !pin_i;
    assign tx_taken_o = start && tx_valid_i;
    assign busy_o     = active;
    assign pin_o      = speedup;
    assign pin_oe_o   = drive_low || speedup;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pin_prev <= 1'b1;
        else
            pin_prev <= pin_i;
    end

    // Counter advances on every debug clock edge of a bit time, at full bus rate
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            active <= 1'b0;
            cnt    <= 4'h0;
        end
        else if (start)
        begin
            active <= 1'b1;
            cnt    <= 4'h0;
        end
        else if (active)
        begin
            if (cnt == rms_pkg::BIT_LAST)
                active <= 1'b0;
            cnt <= cnt + 4'h1;
        end
    end

    // Zero is held low past the host's short pulse, then driven high
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            drive_low <= 1'b0;
        else if (start)
            drive_low <= tx_valid_i && !tx_bit_i;
        else if (active && cnt == rms_pkg::ZERO_LOW_LAST)
            drive_low <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            speedup <= 1'b0;
        else
            speedup <= active && drive_low
                       && cnt == rms_pkg::ZERO_LOW_LAST;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_valid_o <= 1'b0;
            rx_bit_o   <= 1'b0;
        end
        else
        begin
            rx_valid_o <= active && cnt == rms_pkg::RX_SAMPLE_CNT;
            if (active && cnt == rms_pkg::RX_SAMPLE_CNT)
                rx_bit_o <= pin_i;
        end
    end

    bit_len_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start |=> (busy_o && cnt == 4'h0) ##15 (busy_o && cnt == 4'hF)
                  ##1 !busy_o)
        else $error("bit time is not 16 cycles");

    speedup_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $fell(drive_low) |-> (speedup && pin_oe_o) ##1 !speedup)
        else $error("no single speedup pulse after a zero");

    zero_low_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (start && tx_valid_i && !tx_bit_i) |=>
            drive_low[*8] ##1 drive_low[*5] ##1 !drive_low)
        else $error("zero not held low for 13 cycles");

    rx_time_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start |-> ##12 rx_valid_o)
        else $error("receive sample not at cycle 10");

endmodule : rms_bit_timer

// *** rms_reset_mode.sv ***
/*
 * Reset pin and mode select sequencer: drives the open-drain reset pin
 * on every reset, records the cause, samples the debug/mode pin at the
 * end of power-on or debug forced reset and then hands the pin to the
 * debug link bit timer.
 * Assumes arst_n_i is the power-on reset and the internal reset sources
 * arrive as synchronous pulses or levels on the bus clock.
 */
// Function
// - Reset pin reset always ends in user mode
// - Debug mode via low mode pin at reset
// - Internal clock generator selected after any reset
// - Reset pin open drain with pull-up
// - External low on reset pin resets device
// - Reset pin driven low 66 bus cycles
// - Reset cause decoded into cause register
// - Mode pin sampled on power-on or forced reset
// - After reset mode pin becomes debug link
// - Debug mode pin has internal pull-up
// - High mode pin gives normal run mode
// - Each debug link bit lasts 16 cycles
// - Bit timing runs at full bus rate
// - Active-high speedup pulses on debug pin
module rms_reset_mode (
    input  wire logic       ref_clk_i,               // Bus clock
    input  wire logic       arst_n_i,                // Power-on reset
    input  wire logic       reset_pin_i,             // Reset pin level
    output logic            reset_pin_o,             // Reset pin drive
    output logic            reset_pin_oe_o,          // Reset pin enable
    output logic            reset_pin_pu_o,          // Reset pull-up on
    input  wire logic       lvd_rst_i,               // Low voltage reset
    input  wire logic       cop_rst_i,               // Watchdog reset
    input  wire logic       ilop_rst_i,              // Illegal opcode
    input  wire logic       ilad_rst_i,              // Illegal address
    input  wire logic       debug_force_reset_bit_i, // Forced reset write
    input  wire logic       ext_clk_sel_i,           // Use external osc
    input  wire logic       debug_mode_pin_i,        // Debug pin level
    output logic            debug_mode_pin_o,        // Debug pin drive
    output logic            debug_mode_pin_oe_o,     // Debug pin enable
    output logic            debug_mode_pin_pu_o,     // Debug pull-up on
    input  wire logic       link_tx_valid_i,         // Bit to send
    input  wire logic       link_tx_bit_i,           // Value to send
    output logic            link_tx_taken_o,         // Bit taken
    output logic            link_rx_valid_o,         // Bit received
    output logic            link_rx_bit_o,           // Received value
    output logic            link_busy_o,             // Bit in progress
    output logic            sys_rst_n_o,             // Internal reset
    output logic            background_debug_mode_o, // Debug mode
    output logic            run_mode_o,              // Normal run mode
    output logic            clk_src_internal_o,      // Internal clock
    output logic [7:0]      reset_cause_register_o   // Reset cause
);

    logic                rst_pin_meta;
    logic                rst_pin_sync;
    rms_pkg::rms_state_t state;
    rms_pkg::rms_state_t next_state;
    logic [6:0]          drive_cnt;
    logic [7:0]          next_cause;
    logic                reset_req;
    logic                mode_sample_en;
    logic                dbg_mode;
    logic                clk_int;
    logic                link_pin_o;
    logic                link_pin_oe;

    // Pin reset wins, then internal sources, then the forced reset
    function automatic logic [7:0] rms_cause_decode(
        input logic pin_low,
        input logic lvd,
        input logic cop,
        input logic ilop,
        input logic ilad,
        input logic forced
    );
        logic [7:0] c;
        c = 8'h00;
        if (pin_low)
            c[rms_pkg::CAUSE_PIN] = 1'b1;
        else if (lvd)
            c[rms_pkg::CAUSE_LVD] = 1'b1;
        else if (cop)
            c[rms_pkg::CAUSE_COP] = 1'b1;
        else if (ilop)
            c[rms_pkg::CAUSE_ILOP] = 1'b1;
        else if (ilad)
            c[rms_pkg::CAUSE_ILAD] = 1'b1;
        else if (forced)
            c[rms_pkg::CAUSE_FORCED] = 1'b1;
        return c;
    endfunction : rms_cause_decode

    // Two-stage synchroniser on the reset pin
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_pin_meta <= 1'b1;
            rst_pin_sync <= 1'b1;
        end
        else
        begin
            rst_pin_meta <= reset_pin_i;
            rst_pin_sync <= rst_pin_meta;
        end
    end

    assign next_cause = rms_cause_decode(!rst_pin_sync, lvd_rst_i,
                                         cop_rst_i, ilop_rst_i,
                                         ilad_rst_i,
                                         debug_force_reset_bit_i);
    assign reset_req  = (state == rms_pkg::ST_RUN)
                        && (next_cause != 8'h00);

    always_comb
    begin
        next_state = state;
        case (state)
            rms_pkg::ST_DRIVE:
                if (drive_cnt == rms_pkg::RST_DRIVE_LAST)
                    next_state = rms_pkg::ST_WAIT;
            rms_pkg::ST_WAIT:
                // An external hold on the pin stretches the reset
                if (rst_pin_sync)
                    next_state = rms_pkg::ST_SAMPLE;
            rms_pkg::ST_SAMPLE:
                next_state = rms_pkg::ST_RUN;
            rms_pkg::ST_RUN:
                if (reset_req)
                    next_state = rms_pkg::ST_DRIVE;
            default:
                next_state = rms_pkg::ST_DRIVE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state <= rms_pkg::ST_DRIVE;
        else
            state <= next_state;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            drive_cnt <= 7'h00;
        else if (state != rms_pkg::ST_DRIVE)
            drive_cnt <= 7'h00;
        else
            drive_cnt <= drive_cnt + 7'h01;
    end

    // Cause register: power-on at reset, replaced on each later reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            reset_cause_register_o <= rms_pkg::CAUSE_RESET;
        else if (reset_req)
            reset_cause_register_o <= next_cause;
    end

    // Only power-on and forced resets look at the mode pin
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            mode_sample_en <= 1'b1;
        else if (reset_req)
            mode_sample_en <= next_cause[rms_pkg::CAUSE_FORCED];
    end

    // Mode taken as the internal reset releases
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            dbg_mode <= 1'b0;
        else if (reset_req)
            dbg_mode <= 1'b0;
        else if (state == rms_pkg::ST_SAMPLE)
            dbg_mode <= mode_sample_en && !debug_mode_pin_i;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            clk_int <= 1'b1;
        else if (state != rms_pkg::ST_RUN || reset_req)
            clk_int <= 1'b1;
        else
            clk_int <= !ext_clk_sel_i;
    end

    assign sys_rst_n_o             = (state == rms_pkg::ST_RUN);
    assign background_debug_mode_o = dbg_mode;
    assign run_mode_o              = sys_rst_n_o && !dbg_mode;
    assign clk_src_internal_o      = clk_int;
    assign reset_pin_o             = 1'b0;
    assign reset_pin_oe_o          = (state == rms_pkg::ST_DRIVE);
    assign reset_pin_pu_o          = 1'b1;
    assign debug_mode_pin_pu_o     = 1'b1;
    assign debug_mode_pin_o        = link_pin_o;
    assign debug_mode_pin_oe_o     = link_pin_oe && sys_rst_n_o;

    rms_bit_timer u_bit_timer (
        .clk_i      (ref_clk_i),
        .arst_n_i   (arst_n_i),
        .enable_i   (sys_rst_n_o),
        .pin_i      (debug_mode_pin_i),
        .tx_valid_i (link_tx_valid_i),
        .tx_bit_i   (link_tx_bit_i),
        .tx_taken_o (link_tx_taken_o),
        .rx_valid_o (link_rx_valid_o),
        .rx_bit_o   (link_rx_bit_o),
        .busy_o     (link_busy_o),
        .pin_o      (link_pin_o),
        .pin_oe_o   (link_pin_oe)
    );

    // Consecutive cycles of reset pin drive, for checking only
    logic [7:0] oe_run;

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            oe_run <= 8'h00;
        else if (reset_pin_oe_o)
            oe_run <= oe_run + 8'h01;
        else
            oe_run <= 8'h00;
    end

    default clocking rms_cb @(posedge ref_clk_i);
    endclocking

    default disable iff (!arst_n_i);

    drive_len_a: assert property (
        $fell(reset_pin_oe_o) |-> oe_run == rms_pkg::RST_DRIVE_CYCLES)
        else $error("reset pin not driven for 66 cycles");

    drive_bound_a: assert property (
        oe_run <= rms_pkg::RST_DRIVE_CYCLES)
        else $error("reset pin driven longer than 66 cycles");

    pin_drive_rst_a: assert property (
        reset_pin_oe_o |-> !sys_rst_n_o && !reset_pin_o)
        else $error("reset pin driven outside reset");

    pin_reset_a: assert property (
        (sys_rst_n_o && !reset_pin_i)[*3] |=> !sys_rst_n_o && reset_pin_oe_o)
        else $error("external pin low did not reset");

    pin_no_dbg_a: assert property (
        $rose(sys_rst_n_o) && reset_cause_register_o[rms_pkg::CAUSE_PIN]
            |-> !background_debug_mode_o)
        else $error("pin reset entered debug mode");

    dbg_entry_a: assert property (
        (state == rms_pkg::ST_SAMPLE && mode_sample_en && !debug_mode_pin_i)
            |=> background_debug_mode_o && sys_rst_n_o && !run_mode_o)
        else $error("low mode pin did not give debug mode");

    run_entry_a: assert property (
        (state == rms_pkg::ST_SAMPLE && debug_mode_pin_i)
            |=> !background_debug_mode_o && run_mode_o)
        else $error("high mode pin did not give run mode");

    forced_arm_a: assert property (
        (reset_req && next_cause[rms_pkg::CAUSE_FORCED])
            |=> mode_sample_en ##[66:1000] $rose(sys_rst_n_o))
        else $error("forced reset did not arm mode sampling");

    clk_internal_a: assert property (
        (!sys_rst_n_o ##1 sys_rst_n_o) |-> clk_src_internal_o)
        else $error("external clock selected after reset");

    cause_a: assert property (
        (sys_rst_n_o && rst_pin_sync && lvd_rst_i)
            |=> reset_cause_register_o == 8'h02 && !sys_rst_n_o)
        else $error("low voltage cause not recorded");

    link_off_a: assert property (
        !sys_rst_n_o |-> !debug_mode_pin_oe_o)
        else $error("debug pin driven during reset");

    // Main scenarios that the bench should reach
    por_dbg_c: cover property (
        $rose(sys_rst_n_o) && background_debug_mode_o
            && reset_cause_register_o[rms_pkg::CAUSE_POR]);

    pin_reset_c: cover property (
        $rose(sys_rst_n_o) && reset_cause_register_o[rms_pkg::CAUSE_PIN]);

    forced_dbg_c: cover property (
        $rose(sys_rst_n_o) && background_debug_mode_o
            && reset_cause_register_o[rms_pkg::CAUSE_FORCED]);

    link_zero_c: cover property (
        link_tx_taken_o && !link_tx_bit_i);

    link_one_c: cover property (
        link_rx_valid_o && link_rx_bit_o);

endmodule : rms_reset_mode

// *** rms_host_model.sv ***
/*
 * Far-side model: a debug host on the debug/mode pin and a manual
 * switch on the reset pin; also resolves both open-drain wires.
 * Assumes the bench drives sw_low and host_low and calls host_bit.
 */
module rms_host_model (
    input  wire logic clk_i,      // Bus clock
    input  wire logic rst_oe_i,   // Device pulls reset pin low
    input  wire logic dbg_oe_i,   // Device drives debug pin
    input  wire logic dbg_val_i,  // Device debug pin level
    output logic      rst_wire_o, // Reset pin wire level
    output logic      dbg_wire_o  // Debug pin wire level
);
    timeunit 1ns;
    timeprecision 1ns;

    logic sw_low   = 1'b0;
    logic host_low = 1'b0;

    // Pull-up wins unless someone pulls low
    assign rst_wire_o = !(rst_oe_i || sw_low);
    assign dbg_wire_o = dbg_oe_i ? dbg_val_i : !host_low;

    // Host starts a bit with a low of n cycles, short for one, long for zero
    task automatic host_bit(input int n);
        host_low = 1'b1;
        repeat (n) @(posedge clk_i);
        #1;
        host_low = 1'b0;
    endtask : host_bit
endmodule : rms_host_model

// *** reset_and_mode_select_tb_top.sv ***
/*
 * Self-checking bench of the reset and mode select block.
 * Assumes the host model resolves both pins; inputs change 1 ns
 * after each rising clock edge.
 */
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
    err_count++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end

module reset_and_mode_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk_i, arst_n_i, reset_pin_i, reset_pin_o, reset_pin_oe_o;
    logic reset_pin_pu_o, lvd_rst_i, cop_rst_i, ilop_rst_i, ilad_rst_i;
    logic debug_force_reset_bit_i, ext_clk_sel_i, debug_mode_pin_i;
    logic debug_mode_pin_o, debug_mode_pin_oe_o, debug_mode_pin_pu_o;
    logic link_tx_valid_i, link_tx_bit_i, link_tx_taken_o;
    logic link_rx_valid_o, link_rx_bit_o, link_busy_o, sys_rst_n_o;
    logic background_debug_mode_o, run_mode_o, clk_src_internal_o;
    logic [7:0] reset_cause_register_o;
    int err_count = 0;
    int checked   = 0;
    int cycles    = 0;
    int cause_pos [6] = '{rms_pkg::CAUSE_PIN, rms_pkg::CAUSE_LVD,
        rms_pkg::CAUSE_COP, rms_pkg::CAUSE_ILOP, rms_pkg::CAUSE_ILAD,
        rms_pkg::CAUSE_FORCED};

    rms_reset_mode dut_u (
        .ref_clk_i               (ref_clk_i),
        .arst_n_i                (arst_n_i),
        .reset_pin_i             (reset_pin_i),
        .reset_pin_o             (reset_pin_o),
        .reset_pin_oe_o          (reset_pin_oe_o),
        .reset_pin_pu_o          (reset_pin_pu_o),
        .lvd_rst_i               (lvd_rst_i),
        .cop_rst_i               (cop_rst_i),
        .ilop_rst_i              (ilop_rst_i),
        .ilad_rst_i              (ilad_rst_i),
        .debug_force_reset_bit_i (debug_force_reset_bit_i),
        .ext_clk_sel_i           (ext_clk_sel_i),
        .debug_mode_pin_i        (debug_mode_pin_i),
        .debug_mode_pin_o        (debug_mode_pin_o),
        .debug_mode_pin_oe_o     (debug_mode_pin_oe_o),
        .debug_mode_pin_pu_o     (debug_mode_pin_pu_o),
        .link_tx_valid_i         (link_tx_valid_i),
        .link_tx_bit_i           (link_tx_bit_i),
        .link_tx_taken_o         (link_tx_taken_o),
        .link_rx_valid_o         (link_rx_valid_o),
        .link_rx_bit_o           (link_rx_bit_o),
        .link_busy_o             (link_busy_o),
        .sys_rst_n_o             (sys_rst_n_o),
        .background_debug_mode_o (background_debug_mode_o),
        .run_mode_o              (run_mode_o),
        .clk_src_internal_o      (clk_src_internal_o),
        .reset_cause_register_o  (reset_cause_register_o)
    );

    rms_host_model host_u (
        .clk_i      (ref_clk_i),
        .rst_oe_i   (reset_pin_oe_o),
        .dbg_oe_i   (debug_mode_pin_oe_o),
        .dbg_val_i  (debug_mode_pin_o),
        .rst_wire_o (reset_pin_i),
        .dbg_wire_o (debug_mode_pin_i)
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic step();
        @(posedge ref_clk_i);
        #1;
    endtask : step

    // Counts reset pin drive samples until the internal reset lifts
    task automatic rst_wait(output int n, output int bad_clk);
        int i;
        n = 0;
        bad_clk = 0;
        for (i = 0; i < 400 && (i < 8 || sys_rst_n_o !== 1'b1); i++)
        begin
            step();
            if (i == 0)
            begin
                {lvd_rst_i, cop_rst_i, ilop_rst_i, ilad_rst_i} = 4'h0;
                debug_force_reset_bit_i = 1'b0;
            end
            if (i == 4)
            begin
                host_u.sw_low = 1'b0;
            end
            if (reset_pin_oe_o === 1'b1)
            begin
                n++;
            end
            if (sys_rst_n_o !== 1'b1 && clk_src_internal_o !== 1'b1)
            begin
                bad_clk++;
            end
        end
    endtask : rst_wait

    task automatic t_por(input logic mode_low);
        int n;
        int bc;
        arst_n_i = 1'b0;
        host_u.host_low = mode_low;
        repeat (4) step();
        arst_n_i = 1'b1;
        rst_wait(n, bc);
        host_u.host_low = 1'b0;
        `CHK("por_len", 1'b1, (n >= 65 && n <= 67))
        `CHK("por_clk", 0, bc)
        `CHK("por_cause", 8'h80, reset_cause_register_o)
        `CHK("por_dbg", mode_low, background_debug_mode_o)
        `CHK("por_run", !mode_low, run_mode_o)
        `CHK("rst_drive", 1'b0, reset_pin_o)
        `CHK("rst_pu", 1'b1, reset_pin_pu_o)
        `CHK("dbg_pu", 1'b1, debug_mode_pin_pu_o)
        repeat (3) step();
        $display("test por mode_low=%0d done", mode_low);
    endtask : t_por

    task automatic t_reset(input int src, input logic mode_low);
        int n;
        int bc;
        logic [7:0] cause;
        logic dbgm;
        cause = 8'h01 << cause_pos[src];
        dbgm = (src == 5) && mode_low;
        ext_clk_sel_i = 1'b1;
        host_u.host_low = mode_low;
        step();
        `CHK("ext_clk", 1'b0, clk_src_internal_o)
        case (src)
            0: host_u.sw_low = 1'b1;
            1: lvd_rst_i = 1'b1;
            2: cop_rst_i = 1'b1;
            3: ilop_rst_i = 1'b1;
            4: ilad_rst_i = 1'b1;
            default: debug_force_reset_bit_i = 1'b1;
        endcase
        rst_wait(n, bc);
        host_u.host_low = 1'b0;
        `CHK("drive_len", rms_pkg::RST_DRIVE_CYCLES, n)
        `CHK("rst_clk", 0, bc)
        `CHK("cause", cause, reset_cause_register_o)
        `CHK("dbg_mode", dbgm, background_debug_mode_o)
        `CHK("run", !dbgm, run_mode_o)
        ext_clk_sel_i = 1'b0;
        repeat (3) step();
        $display("test reset src=%0d done", src);
    endtask : t_reset

    task automatic t_link(input logic tv, input logic tbit, input int hn,
                          input int ex_low, input logic ex_rx);
        int busy_n;
        int low_n;
        int spd_n;
        int rx_n;
        int i;
        logic rx;
        busy_n = 0;
        low_n = 0;
        spd_n = 0;
        rx_n = 0;
        rx = 1'bx;
        link_tx_valid_i = tv;
        link_tx_bit_i = tbit;
        fork
            host_u.host_bit(hn);
        join_none
        #1;
        `CHK("taken", tv, link_tx_taken_o)
        for (i = 0; i < 18; i++)
        begin
            step();
            busy_n += (link_busy_o === 1'b1);
            low_n += (debug_mode_pin_oe_o === 1'b1 && debug_mode_pin_o === 1'b0);
            spd_n += (debug_mode_pin_oe_o === 1'b1 && debug_mode_pin_o === 1'b1);
            if (link_rx_valid_o === 1'b1)
            begin
                rx_n++;
                rx = link_rx_bit_o;
            end
        end
        link_tx_valid_i = 1'b0;
        step();
        `CHK("busy_len", rms_pkg::BIT_CYCLES, busy_n)
        `CHK("zero_len", ex_low, low_n)
        `CHK("speedup", (ex_low != 0), spd_n)
        `CHK("rx_count", 1, rx_n)
        `CHK("rx_bit", ex_rx, rx)
        $display("test link tv=%0d bit=%0d host=%0d done", tv, tbit, hn);
    endtask : t_link

    initial
    begin
        arst_n_i = 1'b0;
        {lvd_rst_i, cop_rst_i, ilop_rst_i, ilad_rst_i} = 4'h0;
        debug_force_reset_bit_i = 1'b0;
        ext_clk_sel_i = 1'b0;
        link_tx_valid_i = 1'b0;
        link_tx_bit_i = 1'b0;
        t_por(1'b0);
        t_link(1'b1, 1'b0, 4, 13, 1'b0);
        t_link(1'b1, 1'b1, 4, 0, 1'b1);
        t_link(1'b0, 1'b0, 13, 0, 1'b0);
        t_link(1'b0, 1'b0, 4, 0, 1'b1);
        t_reset(5, 1'b1);
        t_reset(0, 1'b1);
        for (int s = 1; s < 5; s++)
        begin
            t_reset(s, 1'b0);
        end
        t_reset(5, 1'b0);
        t_por(1'b1);
        stop_test();
    end
endmodule : reset_and_mode_select_tb_top
